// ### rtl/twm_master.sv
// Two-wire master with its register file
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module twm_master
  import twm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire twm_req_t   req,
  output var  logic [31:0] rdata,
  // Serial lines
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  twm_pins_t  pins,
  // Interrupt
  output var  logic       irq
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_LOW, S_HIGH, S_RSTART, S_PLOW, S_PHIGH, S_PFREE} twm_state_t;
  typedef enum logic [2:0] {K_ADDR, K_INTERNAL_ADDRESS_BYTES, K_RADDR, K_WDATA, K_RDATA} twm_kind_t;

  twm_state_t  state;
  twm_kind_t   kind;
  twm_flags_t  flags;
  logic [6:0]  slave_select_address;
  logic        readDir;
  logic [1:0]  internal_address_size;
  logic [23:0] internal_address_bytes;
  logic [7:0]  scl_low_divider;
  logic [7:0]  scl_high_divider;
  logic [2:0]  scl_divider_exponent;
  logic [31:0] imr;
  logic [7:0]  thr;
  logic [7:0]  rhr;
  logic        thrFull;
  logic        masterEn;
  logic        pendStart;
  logic        stopReq;
  logic [7:0]  shifter;
  logic [3:0]  bitCnt;
  logic [1:0]  iLeft;
  logic [15:0] cnt;
  logic        evRhr;
  logic        evTake;
  logic        evNack;
  logic        evUnder;
  logic        evDone;

  // Decoded accesses
  logic wrCtl, swrst, msenCmd, thrWrite, srRead, rhrRead, busy, startNow, tmo;
  logic [15:0] lowLen, highLen;
  assign wrCtl    = req.wr && req.addr == OFS_CONTROL;
  assign swrst    = wrCtl && req.wdata[CMD_SWRST];
  assign msenCmd  = wrCtl && req.wdata[CMD_MASTER_ENABLE_CMD] && !req.wdata[CMD_MASTER_DISABLE_CMD];
  assign thrWrite = req.wr && req.addr == OFS_TX_HOLD;
  assign srRead   = req.rd && req.addr == OFS_STATUS;
  assign rhrRead  = req.rd && req.addr == OFS_RX_HOLD;
  assign busy     = state != S_IDLE;
  // write frames start on data, reads on command
  assign startNow = !busy && masterEn && (pendStart || (!readDir && thrFull));
  assign lowLen   = phaseLen(scl_low_divider, scl_divider_exponent);
  assign highLen  = phaseLen(scl_high_divider, scl_divider_exponent);
  // Timer end for the current phase; SCL-high states use the high length
  assign tmo = cnt == 16'((state == S_HIGH || state == S_START || state == S_PHIGH || state == S_PFREE)
                          ? highLen - 16'h0001 : lowLen - 16'h0001);

  // Configuration and mask registers
  always_ff @(posedge clk)
  begin
    if (rst || (ce && swrst))
    begin
      slave_select_address    <= WORD_RESET[6:0];
      readDir <= WORD_RESET[0];
      internal_address_size  <= WORD_RESET[1:0];
      internal_address_bytes    <= WORD_RESET[23:0];
      scl_low_divider   <= WORD_RESET[7:0];
      scl_high_divider   <= WORD_RESET[7:0];
      scl_divider_exponent   <= WORD_RESET[2:0];
      imr     <= WORD_RESET;
      thr     <= WORD_RESET[7:0];
    end
    else if (ce && req.wr)
    begin
      unique case (req.addr)
        OFS_MODE:
        begin
          slave_select_address    <= req.wdata[MODE_ADDR_LSB +: 7];
          readDir <= req.wdata[MODE_READ];
          internal_address_size  <= req.wdata[MODE_SIZE_LSB +: 2];
        end
        OFS_IADDR:   internal_address_bytes <= req.wdata[23:0];
        OFS_DIVIDER:
        begin
          scl_low_divider <= req.wdata[7:0];
          scl_high_divider <= req.wdata[DIV_HIGH_LSB +: 8];
          scl_divider_exponent <= req.wdata[DIV_EXP_LSB +: 3];
        end
        OFS_IRQ_SET: imr <= imr | (req.wdata & statusWord('1));
        OFS_IRQ_CLR: imr <= imr & ~req.wdata;
        OFS_TX_HOLD: thr <= req.wdata[7:0];
        default:     imr <= imr;
      endcase
    end
  end

  // Master enable and commands held for the engine
  always_ff @(posedge clk)
  begin
    if (rst || (ce && swrst))
    begin
      masterEn  <= 1'b0;
      pendStart <= 1'b0;
      stopReq   <= 1'b0;
    end
    else if (ce)
    begin
      if (msenCmd)
        masterEn <= 1'b1;
      else if (wrCtl && req.wdata[CMD_MASTER_DISABLE_CMD])
        masterEn <= 1'b0;
      if (wrCtl && req.wdata[CMD_START])
        pendStart <= 1'b1;
      else if (startNow)
        pendStart <= 1'b0;
      // A STOP request outlives the frame only until it has ended it
      if (wrCtl && req.wdata[CMD_STOP])
        stopReq <= 1'b1;
      else if (evDone)
        stopReq <= 1'b0;
    end
  end

  // Frame engine: bit timing, byte sequence, line drive
  always_ff @(posedge clk)
  begin
    if (rst || (ce && swrst))
    begin
      state   <= S_IDLE;
      kind    <= K_ADDR;
      pins    <= '0;
      shifter <= WORD_RESET[7:0];
      bitCnt  <= WORD_RESET[3:0];
      iLeft   <= WORD_RESET[1:0];
      cnt     <= WORD_RESET[15:0];
      rhr     <= WORD_RESET[7:0];
      thrFull <= 1'b0;
      evRhr   <= 1'b0;
      evTake  <= 1'b0;
      evNack  <= 1'b0;
      evUnder <= 1'b0;
      evDone  <= 1'b0;
    end
    else if (ce)
    begin
      evRhr   <= 1'b0;
      evTake  <= 1'b0;
      evNack  <= 1'b0;
      evUnder <= 1'b0;
      evDone  <= 1'b0;
      cnt     <= cnt + 16'h0001;
      unique case (state)
        S_IDLE:
        begin
          cnt <= WORD_RESET[15:0];
          if (startNow)
          begin
            // slave address first; direction bit, write while an address follows
            shifter    <= {slave_select_address, readDir && internal_address_size == 2'b00};
            kind       <= K_ADDR;
            iLeft      <= internal_address_size;
            pins.sdaOe <= 1'b1;
            state      <= S_START;
          end
        end
        S_START:
          if (tmo)
          begin
            cnt <= WORD_RESET[15:0];
            // Repeated start: SDA falls only after a full high phase
            if (!pins.sdaOe)
              pins.sdaOe <= 1'b1;
            else
            begin
              pins.sclOe <= 1'b1;
              bitCnt     <= WORD_RESET[3:0];
              state      <= S_LOW;
            end
          end
        S_LOW:
        begin
          // Data changes one clock after SCL falls
          if (cnt == 16'h0000)
          begin
            if (bitCnt == 4'd8)
              pins.sdaOe <= kind == K_RDATA && !stopReq;
            else
              pins.sdaOe <= kind != K_RDATA && !shifter[7];
          end
          if (tmo)
          begin
            cnt        <= WORD_RESET[15:0];
            pins.sclOe <= 1'b0;
            state      <= S_HIGH;
          end
        end
        S_HIGH:
          if (tmo)
          begin
            cnt        <= WORD_RESET[15:0];
            pins.sclOe <= 1'b1;
            state      <= S_LOW;
            if (bitCnt != 4'd8)
            begin
              shifter <= {shifter[6:0], sdaIn};
              bitCnt  <= bitCnt + 4'd1;
            end
            else
            begin
              bitCnt <= WORD_RESET[3:0];
              if (kind != K_RDATA && sdaIn)
              begin
                evNack <= 1'b1;
                state  <= S_PLOW;
              end
              else if (kind == K_RDATA)
              begin
                rhr   <= shifter;
                evRhr <= 1'b1;
                if (stopReq)
                  state <= S_PLOW;
              end
              else if (kind == K_ADDR && iLeft != 2'b00)
              begin
                // first internal address byte, most significant first
                shifter <= internal_address_bytes[8 * (iLeft - 2'b01) +: 8];
                iLeft   <= iLeft - 2'b01;
                kind    <= K_INTERNAL_ADDRESS_BYTES;
              end
              else if (kind == K_INTERNAL_ADDRESS_BYTES && iLeft != 2'b00)
              begin
                shifter <= internal_address_bytes[8 * (iLeft - 2'b01) +: 8];
                iLeft   <= iLeft - 2'b01;
              end
              else if (readDir && kind != K_RADDR && internal_address_size != 2'b00)
              begin
                // turn round with a repeated start to read
                shifter <= {slave_select_address, 1'b1};
                kind    <= K_RADDR;
                state   <= S_RSTART;
              end
              else if (readDir)
                kind <= K_RDATA;
              else if (thrFull)
              begin
                // holding byte moves into the shifter
                shifter <= thr;
                thrFull <= 1'b0;
                evTake  <= 1'b1;
                kind    <= K_WDATA;
              end
              else
              begin
                // nothing to send: underrun unless STOP was asked; STOP
                evUnder <= !stopReq;
                state   <= S_PLOW;
              end
            end
          end
        S_RSTART:
        begin
          if (cnt == 16'h0000)
            pins.sdaOe <= 1'b0;
          if (tmo)
          begin
            cnt        <= WORD_RESET[15:0];
            pins.sclOe <= 1'b0;
            state      <= S_START;
          end
        end
        S_PLOW:
        begin
          if (cnt == 16'h0000)
            pins.sdaOe <= 1'b1;
          if (tmo)
          begin
            cnt        <= WORD_RESET[15:0];
            pins.sclOe <= 1'b0;
            state      <= S_PHIGH;
          end
        end
        S_PHIGH:
          if (tmo)
          begin
            cnt        <= WORD_RESET[15:0];
            pins.sdaOe <= 1'b0;
            state      <= S_PFREE;
          end
        S_PFREE:
          if (tmo)
          begin
            evDone <= 1'b1;
            state  <= S_IDLE;
          end
      endcase
      // A write frame started by data, with no internal address, raises no take event at its start
      if (startNow && !readDir && internal_address_size == 2'b00 && !pendStart)
        evTake <= 1'b0;
      // A fresh write refills the holding register even if a take happens now
      if (thrWrite)
        thrFull <= 1'b1;
    end
  end

  // Status flags; every hardware set beats a software clear
  always_ff @(posedge clk)
  begin
    if (rst || (ce && swrst))
      flags <= FLAGS_RESET;
    else if (ce)
    begin
      // complete after STOP, on a NACK or on enable; cleared at frame start
      if (msenCmd || evDone || evNack)
        flags.transfer_complete <= 1'b1;
      else if (startNow)
        flags.transfer_complete <= 1'b0;
      if (evRhr)
        flags.receive_ready <= 1'b1;
      else if (rhrRead)
        flags.receive_ready <= 1'b0;
      if (evTake || evNack || msenCmd)
        flags.transmit_ready <= 1'b1;
      else if (thrWrite)
        flags.transmit_ready <= 1'b0;
      // overrun; cleared by status read when complete
      if (evRhr && flags.receive_ready)
        flags.ovr <= 1'b1;
      else if (srRead && flags.transfer_complete)
        flags.ovr <= 1'b0;
      if (evUnder)
        flags.unr <= 1'b1;
      else if (srRead && flags.transfer_complete)
        flags.unr <= 1'b0;
      if (evNack)
        flags.not_acknowledged_flag <= 1'b1;
      else if (srRead)
        flags.not_acknowledged_flag <= 1'b0;
    end
  end

  // Read data for one cycle, and the interrupt line
  always_ff @(posedge clk)
  begin
    if (rst || (ce && swrst))
    begin
      rdata <= WORD_RESET;
      irq   <= 1'b0;
    end
    else if (ce)
    begin
      // any enabled flag raises the line
      irq   <= |(statusWord(flags) & imr);
      rdata <= WORD_RESET;
      if (req.rd)
      begin
        unique case (req.addr)
          OFS_MODE:     rdata <= 32'({slave_select_address, 3'h0, readDir, 2'h0, internal_address_size, 8'h00});
          OFS_IADDR:    rdata <= 32'(internal_address_bytes);
          OFS_DIVIDER:  rdata <= 32'({scl_divider_exponent, scl_high_divider, scl_low_divider});
          OFS_STATUS:   rdata <= statusWord(flags);
          OFS_IRQ_VIEW: rdata <= imr;
          // last byte in the low bits
          OFS_RX_HOLD:  rdata <= 32'(rhr);
          OFS_TX_HOLD:  rdata <= 32'(thr);
          default:      rdata <= WORD_RESET;
        endcase
      end
    end
  end

  // Helper: length of the current SCL level, in enabled cycles
  logic        sclPrev;
  logic [15:0] runCnt;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclPrev <= 1'b0;
      runCnt  <= WORD_RESET[15:0];
    end
    else if (ce)
    begin
      sclPrev <= pins.sclOe;
      runCnt  <= pins.sclOe != sclPrev ? 16'h0001 : runCnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || swrst);

  AST_LOW_PHASE: assert property ($fell(pins.sclOe) && $past(state) == S_LOW |-> runCnt == lowLen)
    else $error("SCL low phase length wrong");
  AST_HIGH_PHASE: assert property ($rose(pins.sclOe) && $past(state) == S_HIGH |-> runCnt == highLen)
    else $error("SCL high phase length wrong");
  AST_FIRST_BYTE: assert property ($rose(busy) |-> shifter[7:1] == slave_select_address)
    else $error("frame does not begin with the slave address");
  AST_DIRECTION: assert property ($rose(busy) |-> shifter[0] == (readDir && internal_address_size == 2'b00))
    else $error("direction bit wrong");
  AST_BUSY_CLEARS: assert property ($rose(busy) |-> !flags.transfer_complete ##1 !flags.transfer_complete)
    else $error("complete flag set at frame start");
  AST_DONE_SETS: assert property (evDone |=> flags.transfer_complete)
    else $error("complete flag missing after STOP");
  AST_RX_READY: assert property (ce && evRhr |=> flags.receive_ready && rhr == $past(rhr))
    else $error("receive ready missing");
  AST_OVERRUN: assert property (ce && evRhr && flags.receive_ready |=> flags.ovr)
    else $error("overrun not flagged");
  AST_TX_CLEAR: assert property (ce && thrWrite && !evTake && !evNack && !msenCmd |=> !flags.transmit_ready)
    else $error("transmit ready not cleared by write");
  AST_UNDER_STOP: assert property (ce && evUnder |-> state == S_PLOW ##1 flags.unr)
    else $error("underrun without STOP");
  AST_STICKY_CLR: assert property (ce && srRead && flags.transfer_complete && !evUnder |=> !flags.unr)
    else $error("underrun not cleared");
  AST_IRQ_LINE: assert property (ce |=> irq == |(statusWord($past(flags)) & $past(imr)))
    else $error("interrupt line disagrees with flags");

  COV_WRITE_DONE: cover property (evTake ##[1:1000] evDone);
  COV_READ_BYTE: cover property (evRhr);
  COV_NOT_ACKNOWLEDGED_FLAG: cover property (evNack);
  COV_UNDERRUN: cover property (evUnder);
  // The far side sees SCL low while the master pulls it
  COV_SCL_PULLED: cover property (pins.sclOe && !sclIn);
endmodule
`default_nettype wire

// ### rtl/twm_pkg.sv
// Constants and types of the two-wire master register block
package twm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_MODE     = 8'h04;
  localparam logic [7:0] OFS_IADDR    = 8'h0c;
  localparam logic [7:0] OFS_DIVIDER  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_IRQ_SET  = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;
  localparam logic [7:0] OFS_IRQ_VIEW = 8'h2c;
  localparam logic [7:0] OFS_RX_HOLD  = 8'h30;
  localparam logic [7:0] OFS_TX_HOLD  = 8'h34;
  // Command bits of the control register
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;
  localparam int CMD_MASTER_ENABLE_CMD  = 2;
  localparam int CMD_MASTER_DISABLE_CMD = 3;
  localparam int CMD_SWRST = 7;
  // Mode and divider field positions
  localparam int MODE_SIZE_LSB = 8;
  localparam int MODE_READ     = 12;
  localparam int MODE_ADDR_LSB = 16;
  localparam int DIV_HIGH_LSB  = 8;
  localparam int DIV_EXP_LSB   = 16;
  // Status bit positions
  localparam int ST_TRANSFER_COMPLETE = 0;
  localparam int ST_RECEIVE_READY  = 1;
  localparam int ST_TRANSMIT_READY  = 2;
  localparam int ST_OVERRUN_FLAG   = 6;
  localparam int ST_UNDERRUN_FLAG   = 7;
  localparam int ST_NOT_ACKNOWLEDGED_FLAG   = 8;
  // Fixed part of every SCL phase, in clocks
  localparam logic [15:0] SCL_EXTRA = 16'h0003;
  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } twm_req_t;

  // Open-drain line enables, high while pulling low
  typedef struct packed {
    logic sclOe;
    logic sdaOe;
  } twm_pins_t;

  // Status flags
  typedef struct packed {
    logic not_acknowledged_flag;
    logic unr;
    logic ovr;
    logic transmit_ready;
    logic receive_ready;
    logic transfer_complete;
  } twm_flags_t;

  localparam twm_flags_t FLAGS_RESET = '0;

  // Place the flags at their status word positions
  function automatic logic [31:0] statusWord(input twm_flags_t f);
    logic [31:0] w;
    w = WORD_RESET;
    w[ST_TRANSFER_COMPLETE] = f.transfer_complete;
    w[ST_RECEIVE_READY] = f.receive_ready;
    w[ST_TRANSMIT_READY] = f.transmit_ready;
    w[ST_OVERRUN_FLAG] = f.ovr;
    w[ST_UNDERRUN_FLAG] = f.unr;
    w[ST_NOT_ACKNOWLEDGED_FLAG] = f.not_acknowledged_flag;
    return w;
  endfunction

  // SCL phase length in clocks
  function automatic logic [15:0] phaseLen(input logic [7:0] div, input logic [2:0] exp);
    return 16'((16'(div) << exp) + SCL_EXTRA);
  endfunction
endpackage

// ### tb/twm_slave_model.sv
// Behavioural two-wire slave: acks, answers reads, logs written bytes
`timescale 1ns/1ns
`default_nettype none
module twm_slave_model
  import twm_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Line levels after the pull-ups
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour controls
  input  wire logic [7:0] rdByte,
  input  wire logic       nackData,
  // Slave pull-down enable
  output var  logic       sdaOe
);
  logic [7:0] got [0:7];
  logic [7:0] shift = 8'h00;
  logic       sclQ = 1'b1;
  logic       sdaQ = 1'b1;
  logic       reading = 1'b0;
  logic       first = 1'b0;
  logic       ackSeen = 1'b1;
  int         bitCnt = 0;
  int         nBytes = 0;
  int         stops = 0;

  initial sdaOe = 1'b0;

  // Line events seen on the system clock; pull-ups make a released line high
  always @(posedge clk)
  begin
    sclQ <= scl;
    sdaQ <= sda;
    if (sclQ && scl && sdaQ && !sda)
    begin
      bitCnt  <= 0;
      first   <= 1'b1;
      reading <= 1'b0;
    end
    else if (sclQ && scl && !sdaQ && sda)
      stops <= stops + 1;
    else if (!sclQ && scl)
    begin
      // Rising SCL samples data, or the master's acknowledge as ninth bit
      if (bitCnt < 8)
        shift <= {shift[6:0], sda};
      else
        ackSeen <= sda;
      bitCnt <= bitCnt + 1;
    end
    else if (sclQ && !scl)
    begin
      if (bitCnt == 8 && !reading)
      begin
        got[nBytes % 8] <= shift;
        nBytes  <= nBytes + 1;
        first   <= 1'b0;
        reading <= first & shift[0];
        sdaOe   <= first | !nackData;
      end
      else if (bitCnt == 9)
      begin
        // A master not-acknowledge ends our sending so it can STOP
        bitCnt  <= 0;
        reading <= reading & !ackSeen;
        sdaOe   <= reading & !ackSeen & !rdByte[7];
      end
      else if (reading)
        sdaOe <= (bitCnt < 8) & !rdByte[3'(7 - bitCnt)];
    end
  end
endmodule
`default_nettype wire

// ### tb/twm_master_tb_top.sv
// Self-checking bench for the two-wire master register block
`timescale 1ns/1ns
`default_nettype none
module twm_master_tb_top
  import twm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  twm_req_t    req = '0;
  logic [31:0] rdata;
  twm_pins_t   pins;
  logic        irq;
  logic        slvOe;
  logic [7:0]  rdByte = 8'hc3;
  logic        nackData = 1'b0;
  int          err_count = 0;
  int          samples_checked = 0;
  // Open-drain lines with pull-ups
  wire logic   scl = !pins.sclOe;
  wire logic   sda = !(pins.sdaOe | slvOe);

  always #2 clk = !clk;

  twm_master dut_u (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
                    .sclIn(scl), .sdaIn(sda), .pins(pins), .irq(irq));
  twm_slave_model slave_u (.clk(clk), .scl(scl), .sda(sda), .rdByte(rdByte),
                           .nackData(nackData), .sdaOe(slvOe));

  task automatic test_done();
    $display("Checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask))
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
    end
  endtask

  // Bus cycles: strobe for one cycle, read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(rdata, exp, mask);
  endtask

  // Interrupt is registered behind the flags, so allow two cycles
  task automatic irqChk(input logic exp);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, {31'h0, exp}, 32'h1);
  endtask

  // Wait for a STOP on the wire, then let the completion flag land
  task automatic waitStops(input int n);
    for (int k = 0; k < 20000 && slave_u.stops < n; k++)
      @(posedge clk);
    if (slave_u.stops < n)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, slave_u.stops, n);
      test_done();
    end
    repeat (40) @(posedge clk);
  endtask

  task automatic t_regs();
    rdChk(OFS_STATUS, WORD_RESET, '1);
    rdChk(OFS_IRQ_VIEW, WORD_RESET, '1);
    wr(8'h08, 32'hffff_ffff);
    rdChk(8'h08, WORD_RESET, '1);
    rdChk(OFS_CONTROL, WORD_RESET, '1);
    wr(OFS_MODE, 32'h005a_1300);
    rdChk(OFS_MODE, 32'h005a_1300, 32'h007f_1300);
    wr(OFS_IADDR, 32'h0012_3456);
    rdChk(OFS_IADDR, 32'h0012_3456, 32'h00ff_ffff);
  endtask

  task automatic t_irqMask();
    wr(OFS_IRQ_SET, 32'h0000_01c7);
    rdChk(OFS_IRQ_VIEW, 32'h0000_01c7, '1);
    wr(OFS_IRQ_CLR, 32'h0000_0041);
    rdChk(OFS_IRQ_VIEW, 32'h0000_0186, '1);
    wr(OFS_IRQ_SET, 32'h0);
    rdChk(OFS_IRQ_VIEW, 32'h0000_0186, '1);
    wr(OFS_IRQ_CLR, 32'h0000_0186);
    rdChk(OFS_IRQ_VIEW, 32'h0, '1);
  endtask

  task automatic t_enable();
    wr(OFS_CONTROL, 32'h0000_000c);
    rdChk(OFS_STATUS, 32'h0, 32'h5);
    wr(OFS_CONTROL, 32'h0000_0004);
    rdChk(OFS_STATUS, 32'h5, 32'h5);
    wr(OFS_IRQ_SET, 32'h1);
    irqChk(1'b1);
    wr(OFS_IRQ_CLR, 32'h1);
    irqChk(1'b0);
  endtask

  // Write with three internal bytes; holding runs dry after one data byte
  task automatic t_write();
    logic [7:0] expBytes [0:4];
    int base;
    int n;
    expBytes = '{8'hb4, 8'h12, 8'h34, 8'h56, 8'ha5};
    base = slave_u.nBytes;
    wr(OFS_MODE, 32'h005a_0300);
    wr(OFS_DIVIDER, 32'h0002_0103);
    wr(OFS_TX_HOLD, 32'h0000_00a5);
    rdChk(OFS_STATUS, 32'h0, 32'h5);
    for (n = 0; n < 4000 && scl; n++)
      @(negedge clk);
    for (n = 0; n < 4000 && !scl; n++)
      @(negedge clk);
    check(32'(n), 32'd15, '1);
    for (n = 0; n < 4000 && scl; n++)
      @(negedge clk);
    check(32'(n), 32'd7, '1);
    waitStops(1);
    check(32'(slave_u.nBytes - base), 32'd5, '1);
    for (int i = 0; i < 5; i++)
      check({24'h0, slave_u.got[(base + i) % 8]}, {24'h0, expBytes[i]}, 32'hff);
    rdChk(OFS_STATUS, 32'h81, 32'h81);
    rdChk(OFS_STATUS, 32'h0, 32'h80);
  endtask

  // Two reads without draining the receive holding register
  task automatic t_read();
    int base;
    base = slave_u.nBytes;
    wr(OFS_MODE, 32'h003c_1000);
    wr(OFS_CONTROL, 32'h0000_0003);
    waitStops(2);
    check({24'h0, slave_u.got[base % 8]}, 32'h79, 32'hff);
    rdChk(OFS_STATUS, 32'h02, 32'h42);
    wr(OFS_CONTROL, 32'h0000_0003);
    waitStops(3);
    rdChk(OFS_STATUS, 32'h43, 32'h43);
    rdChk(OFS_STATUS, 32'h0, 32'h40);
    rdChk(OFS_RX_HOLD, 32'h0000_00c3, '1);
    rdChk(OFS_STATUS, 32'h0, 32'h2);
  endtask

  // Slave refuses the data byte
  task automatic t_not_acknowledged_flag();
    nackData <= 1'b1;
    wr(OFS_MODE, 32'h005a_0000);
    wr(OFS_IRQ_SET, 32'h0000_0100);
    wr(OFS_TX_HOLD, 32'h0000_0011);
    waitStops(4);
    irqChk(1'b1);
    rdChk(OFS_STATUS, 32'h105, 32'h105);
    rdChk(OFS_STATUS, 32'h0, 32'h100);
    irqChk(1'b0);
    nackData <= 1'b0;
  endtask

  // Clock enable low freezes the registers; a soft reset then clears them
  task automatic t_freeze();
    rdChk(OFS_DIVIDER, 32'h0002_0103, 32'h0007_ffff);
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_IADDR, 32'h0000_00ff);
    ce <= 1'b1;
    rdChk(OFS_IADDR, 32'h0012_3456, 32'h00ff_ffff);
    wr(OFS_CONTROL, 32'h0000_0080);
    rdChk(OFS_MODE, WORD_RESET, '1);
    rdChk(OFS_STATUS, WORD_RESET, '1);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_irqMask();
    t_enable();
    t_write();
    t_read();
    t_not_acknowledged_flag();
    t_freeze();
    test_done();
  end
endmodule
`default_nettype wire
